// ### core/adc_seq_defines.svh
// Overview of operation
// RULE1 - Sixteen external channels plus temperature sensor; any step picks any input.
// RULE2 - Four sequences with own triggers; depths eight, four, four and one.
// RULE3 - Highest-priority triggered sequence is captured first.
// RULE4 - Software should not give frequent triggers high priority; starvation risk.
// RULE5 - Averaging 2x to 64x, common to all sequences, throughput divided.
// RULE6 - One comparator word holds independent trigger and interrupt conditions.
// RULE7 - Trigger condition off never raises the fault trigger.
// RULE8 - Continuous modes fire for every result inside the chosen band.
// RULE9 - Entry modes fire once when a result moves into the band.
// RULE10 - Low hysteresis modes need a high result since the last firing.
// RULE11 - High hysteresis modes need a low result since the last firing.
// RULE12 - Low hysteresis entry fires only on entry into low after high.
// RULE13 - Interrupt condition off never raises the interrupt.
// RULE14 - Interrupt offers the same eleven conditions as the fault trigger.
// RULE15 - Low band at or below low threshold; high above high threshold.
// RULE16 - Trigger state and interrupt state have separate resets.
// RULE17 - Averaging factor zero stores single conversions.
// RULE18 - Trigger and interrupt paths keep separate entry and hysteresis state.
// RULE19 - After reset, paths have no previous band and hysteresis is disarmed.
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH
// ----------------------------------------
// Sequence geometry
// ----------------------------------------
`define SEQ0_DEPTH   4'h8
`define SEQ1_DEPTH   4'h4
`define SEQ2_DEPTH   4'h4
`define SEQ3_DEPTH   4'h1
`define SEQ0_BASE    5'h00
`define SEQ1_BASE    5'h08
`define SEQ2_BASE    5'h0c
`define SEQ3_BASE    5'h10
`define STEP_TOTAL   17
`define TEMP_CHANNEL 5'h10
`define AVG_LOG2_MAX 3'h6
`endif

// ### core/adc_seq_pkg.sv
package adc_seq_pkg;
  localparam int DATA_W = 12;
  typedef enum logic [1:0] {band_low, band_mid, band_high, band_none} band_type;
  typedef enum logic [3:0] {
    fault_trig_off, fault_trig_low_continuous, fault_trig_low_entry,
    fault_trig_low_hyst_continuous, fault_trig_low_hyst_entry,
    fault_trig_mid_continuous, fault_trig_mid_entry,
    fault_trig_high_continuous, fault_trig_high_entry,
    fault_trig_high_hyst_continuous, fault_trig_high_hyst_entry
  } cond_type;
  typedef enum logic [1:0] {st_idle, st_start, st_wait, st_store} fsm_type;
  typedef struct packed {
    band_type prev;
    logic     arm_low;
    logic     arm_high;
  } cmp_path_type;
  typedef struct packed {
    logic [1:0]        seq;
    logic [2:0]        step;
    logic              last;
    logic [DATA_W-1:0] value;
  } sample_type;
  typedef struct packed {
    cond_type trig_cond;
    cond_type irq_cond;
  } cmp_cfg_type;
  typedef struct packed {
    sample_type [1:0]  buf_q;
    logic [1:0]        vld;
    fsm_type           fsm;
    logic [1:0]        seq;
    logic [2:0]        step;
    logic [DATA_W+5:0] acc;
    logic [6:0]        avg_cnt;
    logic [3:0]        pend;
    logic              conv_start;
    logic [4:0]        conv_chan;
    cmp_path_type      trig_path;
    cmp_path_type      irq_path;
    logic              fault_trig;
    logic              band_irq;
    logic              busy;
  } state_type;
endpackage

// ### core/adc_sequencer_digital_comparator.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_defines.svh"
module adc_sequencer_digital_comparator #(
  parameter logic [2:0] MAX_AVG_LOG2 = `AVG_LOG2_MAX // Largest averaging exponent served
) (
  input  wire logic                                mclk,              // 25 MHz clock
  input  wire logic                                rst_n,             // Async reset, low
  input  wire logic [3:0]                          seq_trig,          // Trigger per sequence
  input  wire logic [3:0]                          seq_enable,        // Sequence enables
  input  wire logic [3:0][1:0]                     seq_prio,          // 0 is highest
  input  wire logic [3:0][2:0]                     seq_last_step,     // Last step index
  input  wire logic [`STEP_TOTAL-1:0][4:0]         step_chan,         // Channel per step
  input  wire logic [2:0]                          avg_log2,          // 0 off, n gives 2^n, clamped to MAX_AVG_LOG2
  input  wire logic                                conv_done,         // Conversion finished
  input  wire logic [adc_seq_pkg::DATA_W-1:0]      conv_data,         // Conversion result
  input  wire logic [adc_seq_pkg::DATA_W-1:0]      low_band_threshold,  // Low/mid edge
  input  wire logic [adc_seq_pkg::DATA_W-1:0]      high_band_threshold, // Mid/high edge
  input  wire adc_seq_pkg::cmp_cfg_type            cmp_cfg,           // Both conditions
  input  wire logic                                cmp_trig_reset,    // Clear trigger path
  input  wire logic                                cmp_irq_reset,     // Clear irq path
  input  wire logic                                out_ready,         // Reader accepts
  output logic                                     out_valid,         // Sample available
  output adc_seq_pkg::sample_type                  out_data,          // Head sample
  output logic                                     conv_start,        // Start pulse
  output logic [4:0]                               conv_chan,         // Channel to convert
  output logic                                     fault_trig,        // Pulse to PWM fault
  output logic                                     band_irq,          // Interrupt pulse
  output logic                                     busy               // Sequence running
);
  import adc_seq_pkg::*;

  localparam cmp_path_type PATH_INIT = '{prev: band_none, arm_low: 1'b0, arm_high: 1'b0};

  if (MAX_AVG_LOG2 > `AVG_LOG2_MAX)
  begin : g_avg_limit
    $error("MAX_AVG_LOG2 above the supported 64x");
  end

  // ----------------------------------------
  // Comparator condition helpers
  // ----------------------------------------
  // Entry counts against the previous band; none after reset makes the first result an entry
  function automatic logic cond_fire(cond_type m, band_type b, cmp_path_type p);
    logic entry;
    entry = (b != p.prev);
    case (m)
      fault_trig_low_continuous:       cond_fire = (b == band_low);              // [RULE8]
      fault_trig_mid_continuous:       cond_fire = (b == band_mid);              // [RULE8]
      fault_trig_high_continuous:      cond_fire = (b == band_high);             // [RULE8]
      fault_trig_low_entry:            cond_fire = (b == band_low) && entry;     // [RULE9]
      fault_trig_mid_entry:            cond_fire = (b == band_mid) && entry;     // [RULE9]
      fault_trig_high_entry:           cond_fire = (b == band_high) && entry;    // [RULE9]
      fault_trig_low_hyst_continuous:  cond_fire = (b == band_low) && p.arm_low;   // [RULE10]
      fault_trig_low_hyst_entry:       cond_fire = (b == band_low) && entry && p.arm_low; // [RULE12]
      fault_trig_high_hyst_continuous: cond_fire = (b == band_high) && p.arm_high; // [RULE11]
      fault_trig_high_hyst_entry:      cond_fire = (b == band_high) && entry && p.arm_high; // [RULE11]
      default:                         cond_fire = 1'b0;                         // [RULE7] [RULE13]
    endcase
  endfunction

  // Arming follows the opposite band; a firing hysteresis mode disarms itself
  function automatic cmp_path_type path_next(cond_type m, band_type b, cmp_path_type p, logic f);
    cmp_path_type n;
    n = p;
    n.prev = b;
    if (b == band_high)
      n.arm_low = 1'b1;                                                          // [RULE10]
    if (b == band_low)
      n.arm_high = 1'b1;                                                         // [RULE11]
    if (f && (m == fault_trig_low_hyst_continuous || m == fault_trig_low_hyst_entry))
      n.arm_low = 1'b0;
    if (f && (m == fault_trig_high_hyst_continuous || m == fault_trig_high_hyst_entry))
      n.arm_high = 1'b0;
    path_next = n;
  endfunction

  state_type  st;
  state_type  next_st;
  logic       push;
  band_type   push_band;
  logic [2:0] avg_eff;
  logic       trig_fire;
  logic       irq_fire;

  assign out_valid  = st.vld[0];
  assign out_data   = st.buf_q[0];
  assign conv_start = st.conv_start;
  assign conv_chan  = st.conv_chan;
  assign fault_trig = st.fault_trig;
  assign band_irq   = st.band_irq;
  assign busy       = st.busy;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  // One process computes the whole next state; outputs then come straight from flops
  always_comb
  begin
    logic [1:0]        best;
    logic [1:0]        best_prio;
    logic              found;
    logic [4:0]        base;
    logic [2:0]        last;
    logic [2:0]        cap;
    logic [DATA_W+5:0] avg;
    sample_type        smp;
    best      = 2'h0;
    best_prio = 2'h3;
    found     = 1'b0;
    base      = `SEQ0_BASE;
    last      = 3'h0;
    cap       = 3'h0;
    avg       = '0;
    smp       = '0;
    push      = 1'b0;
    trig_fire = 1'b0;
    irq_fire  = 1'b0;
    next_st   = st;
    next_st.conv_start = 1'b0;
    next_st.fault_trig = 1'b0;
    next_st.band_irq   = 1'b0;
    // Triggers are held until their sequence is granted, so none is lost while busy
    next_st.pend = st.pend | (seq_trig & seq_enable);                            // [RULE2]
    // Factor zero means single conversions; larger requests clamp to the limit
    avg_eff = (avg_log2 > MAX_AVG_LOG2) ? MAX_AVG_LOG2 : avg_log2;               // [RULE17]
    // Table base and depth cap of the running sequence; a larger last step is clamped
    case (st.seq)
      2'h0:    {base, cap} = {`SEQ0_BASE, 3'(`SEQ0_DEPTH - 4'h1)};
      2'h1:    {base, cap} = {`SEQ1_BASE, 3'(`SEQ1_DEPTH - 4'h1)};
      2'h2:    {base, cap} = {`SEQ2_BASE, 3'(`SEQ2_DEPTH - 4'h1)};
      default: {base, cap} = {`SEQ3_BASE, 3'(`SEQ3_DEPTH - 4'h1)}; // [RULE2]
    endcase
    last = (seq_last_step[st.seq] > cap) ? cap : seq_last_step[st.seq];
    // Reader side of the two-entry buffer shifts the head out
    if (st.vld[0] && out_ready)
    begin
      next_st.buf_q[0] = st.buf_q[1];
      next_st.vld      = {1'b0, st.vld[1]};
    end
    case (st.fsm)
      st_idle:
      begin
        // Lowest priority value wins; equal values go to the lower sequence number
        for (int i = 0; i < 4; i++)
        begin
          if (st.pend[i] && (!found || seq_prio[i] < best_prio))
          begin
            found     = 1'b1;
            best      = 2'(i);
            best_prio = seq_prio[i];                                             // [RULE3]
          end
        end
        if (found)
        begin
          next_st.seq        = best;
          next_st.step       = 3'h0;
          next_st.acc        = '0;
          next_st.avg_cnt    = 7'h00;
          next_st.pend[best] = 1'b0;
          next_st.fsm        = st_start;
          next_st.busy       = 1'b1;
        end
      end
      st_start:
      begin
        // Any of the 17 inputs per step, repeats allowed
        next_st.conv_start = 1'b1;
        next_st.conv_chan  = step_chan[5'(base + 5'(st.step))];                  // [RULE1]
        next_st.fsm        = st_wait;
      end
      st_wait:
      begin
        if (conv_done)
        begin
          next_st.acc     = st.acc + (DATA_W+6)'(conv_data);
          next_st.avg_cnt = st.avg_cnt + 7'h01;
          // Each stored word costs 2^n conversions, dividing throughput by the factor
          if ((st.avg_cnt + 7'h01) == (7'h01 << avg_eff))
            next_st.fsm = st_store;                                              // [RULE5]
          else
            next_st.fsm = st_start;
        end
      end
      st_store:
      begin
        // Stall here while the buffer is full so no result is dropped
        if (!next_st.vld[1])
        begin
          avg          = st.acc >> avg_eff;                                      // [RULE5]
          smp.seq      = st.seq;
          smp.step     = st.step;
          smp.last     = (st.step == last);
          smp.value    = avg[DATA_W-1:0];
          push         = 1'b1;
          if (next_st.vld[0])
          begin
            next_st.buf_q[1] = smp;
            next_st.vld[1]   = 1'b1;
          end
          else
          begin
            next_st.buf_q[0] = smp;
            next_st.vld[0]   = 1'b1;
          end
          next_st.acc     = '0;
          next_st.avg_cnt = 7'h00;
          if (st.step == last)
          begin
            next_st.fsm  = st_idle;
            next_st.busy = 1'b0;
          end
          else
          begin
            next_st.step = st.step + 3'h1;
            next_st.fsm  = st_start;
          end
        end
      end
      default:
        next_st.fsm = st_idle;
    endcase
    // Band of the stored result: thresholds themselves belong to the lower band
    if (avg[DATA_W-1:0] <= low_band_threshold)
      push_band = band_low;                                                      // [RULE15]
    else if (avg[DATA_W-1:0] <= high_band_threshold)
      push_band = band_mid;
    else
      push_band = band_high;
    // Two independent paths from one configuration word, each with its own memory
    if (push)
    begin
      trig_fire          = cond_fire(cmp_cfg.trig_cond, push_band, st.trig_path); // [RULE6]
      irq_fire           = cond_fire(cmp_cfg.irq_cond, push_band, st.irq_path);   // [RULE14]
      next_st.fault_trig = trig_fire;
      next_st.band_irq   = irq_fire;
      next_st.trig_path  = path_next(cmp_cfg.trig_cond, push_band, st.trig_path, trig_fire); // [RULE18]
      next_st.irq_path   = path_next(cmp_cfg.irq_cond, push_band, st.irq_path, irq_fire);
    end
    // Software resets win over an update in the same cycle
    if (cmp_trig_reset)
      next_st.trig_path = PATH_INIT;                                             // [RULE16]
    if (cmp_irq_reset)
      next_st.irq_path = PATH_INIT;                                              // [RULE16]
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st           <= '0;
      st.trig_path <= PATH_INIT;                                                 // [RULE19]
      st.irq_path  <= PATH_INIT;                                                 // [RULE19]
    end
    else
      st <= next_st;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_trig_push(cond_type m);
    push && !cmp_trig_reset && cmp_cfg.trig_cond == m;
  endsequence

  a_trig_off_quiet: assert property (s_trig_push(fault_trig_off) |=> !fault_trig) // [RULE7]
    else $error("fault trigger raised while condition is off");
  a_irq_off_quiet: assert property ((push && cmp_cfg.irq_cond == fault_trig_off) |=> !band_irq) // [RULE13]
    else $error("interrupt raised while condition is off");
  a_low_cont_fire: assert property ((s_trig_push(fault_trig_low_continuous) ##0 push_band == band_low) |=> fault_trig) // [RULE8]
    else $error("continuous low result did not trigger");
  a_irq_mid_cont: assert property ((push && cmp_cfg.irq_cond == fault_trig_mid_continuous && push_band == band_mid) |=> band_irq) // [RULE14]
    else $error("continuous mid result did not interrupt");
  a_entry_repeat_quiet: assert property ((s_trig_push(fault_trig_high_entry) ##0 st.trig_path.prev == band_high) |=> !fault_trig) // [RULE9]
    else $error("entry mode fired without a band change");
  a_low_hyst_arm: assert property ((s_trig_push(fault_trig_low_hyst_continuous) ##0 !st.trig_path.arm_low) |=> !fault_trig) // [RULE10]
    else $error("low hysteresis fired while disarmed");
  a_high_hyst_arm: assert property ((s_trig_push(fault_trig_high_hyst_continuous) ##0 !st.trig_path.arm_high) |=> !fault_trig) // [RULE11]
    else $error("high hysteresis fired while disarmed");
  a_low_hyst_entry: assert property ((s_trig_push(fault_trig_low_hyst_entry) ##0 (st.trig_path.prev == band_low || !st.trig_path.arm_low)) |=> !fault_trig) // [RULE12]
    else $error("low hysteresis entry fired wrongly");
  a_reset_path_clear: assert property (cmp_trig_reset |=> st.trig_path.prev == band_none && !st.trig_path.arm_low && !st.trig_path.arm_high) // [RULE16]
    else $error("trigger path not cleared by reset request");
  a_single_conv: assert property ((st.fsm == st_wait && conv_done && avg_log2 == 3'h0) |=> st.fsm == st_store) // [RULE17]
    else $error("averaging off did not store after one conversion");
endmodule
`default_nettype wire

// ### test/conv_front_model.sv
`timescale 1ns/1ps
`default_nettype none
module conv_front_model
  import adc_seq_pkg::*;
(
  input  wire logic              mclk,      // System clock
  input  wire logic              rst_n,     // Async reset, low
  input  wire logic              conv_start, // Start request from the block
  input  wire logic [4:0]        conv_chan, // Selected input
  input  wire logic              slow,      // Stretch conversion time
  input  wire logic [DATA_W-1:0] base_data, // Analog level seen by the model
  output logic                   conv_done, // Result strobe
  output logic [DATA_W-1:0]      conv_data  // Result, only valid with strobe
);
  logic [2:0] wait_cnt;
  logic [DATA_W-1:0] result;

  // ----------------------------------------
  // One conversion at a time
  // ----------------------------------------
  // Result mixes in the channel so a wrong channel pick shows in the data.
  // Outside the strobe the data toggles so stale values are never trusted.
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_cnt  <= 3'h0;
      conv_done <= 1'b0;
      conv_data <= 12'hfff;
    end
    else
    begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (conv_start && !slow)
      begin
        conv_done <= 1'b1;
        conv_data <= base_data ^ {7'h00, conv_chan};
      end
      else if (conv_start)
      begin
        wait_cnt <= 3'h5;
        result   <= base_data ^ {7'h00, conv_chan};
      end
      else if (wait_cnt != 3'h0)
      begin
        wait_cnt <= wait_cnt - 3'h1;
        if (wait_cnt == 3'h1)
        begin
          conv_done <= 1'b1;
          conv_data <= result;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_defines.svh"
`define CHK(nm, e, g) begin logic [31:0] ev, gv; ev = 32'(e); gv = 32'(g); \
  n_compared++; if (gv !== ev) begin miscompares++; \
  $display("MISMATCH %s exp %0h got %0h", nm, ev, gv); end end
module tb;
  import adc_seq_pkg::*;
  logic mclk, rst_n, conv_done, conv_start, out_valid, out_ready, fault_trig, band_irq;
  logic busy, cmp_trig_reset, cmp_irq_reset, slow;
  logic [3:0]                  seq_trig, seq_enable;
  logic [3:0][1:0]             seq_prio;
  logic [3:0][2:0]             seq_last_step;
  logic [`STEP_TOTAL-1:0][4:0] step_chan;
  logic [2:0]                  avg_log2;
  logic [4:0]                  conv_chan;
  logic [DATA_W-1:0]           conv_data, base_data, low_band_threshold, high_band_threshold;
  cmp_cfg_type                 cmp_cfg;
  sample_type                  out_data;
  cmp_path_type                ptrig, pirq;
  int                          miscompares, n_compared, seed, n_conv;

  adc_sequencer_digital_comparator adc_sequencer_digital_comparator_i (.*);
  conv_front_model conv_front_model_i (.*);

  // ----------------------------------------
  // Clock and helpers
  // ----------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) if (conv_start === 1'b1) n_conv++;

  task automatic tick;
    @(negedge mclk);
  endtask

  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Bounded wait; a hang ends the run as a failure
  task automatic wait_valid;
    int t;
    for (t = 0; t < 3000 && out_valid !== 1'b1; t++) tick;
    if (t == 3000)
    begin
      miscompares++;
      close_out;
    end
  endtask

  task automatic pop;
    out_ready = 1'b1;
    tick;
    out_ready = 1'b0;
  endtask

  // Expected firing of one path; k is the condition code, b the band
  function automatic logic fires(inout cmp_path_type p, input int k, input band_type b);
    band_type tgt;
    logic     f;
    tgt = (k <= 4) ? band_low : (k <= 6) ? band_mid : band_high;
    f = k >= 1 && k <= 10 && b == tgt;
    if (k inside {2, 4, 6, 8, 10}) f = f && p.prev != b;
    if (k inside {3, 4}) f = f && p.arm_low;
    if (k inside {9, 10}) f = f && p.arm_high;
    if (f) {p.arm_low, p.arm_high} = 2'b00;
    if (b == band_high) p.arm_low = 1'b1;
    if (b == band_low) p.arm_high = 1'b1;
    p.prev = b;
    return f;
  endfunction

  // Runs one sequence; stall leaves the reader idle so the buffer fills
  task automatic run_seq(input int s, input int stall);
    int n, b;
    n = (s == 0) ? `SEQ0_DEPTH : (s == 3) ? `SEQ3_DEPTH : `SEQ1_DEPTH;
    if (seq_last_step[s] + 1 < n) n = seq_last_step[s] + 1;
    b = (s == 0) ? `SEQ0_BASE : (s == 1) ? `SEQ1_BASE : (s == 2) ? `SEQ2_BASE : `SEQ3_BASE;
    n_conv = 0;
    seq_trig[s] = 1'b1;
    tick;
    seq_trig = 4'h0;
    if (stall) repeat (60) tick;
    for (int i = 0; i < n; i++)
    begin
      wait_valid;
      `CHK("out_data", sample_type'({s[1:0], i[2:0], i == n - 1, base_data ^ {7'h00, step_chan[b + i]}}), out_data)
      pop;
    end
    tick;
    `CHK("conversions", n << ((avg_log2 > 6) ? 6 : avg_log2), n_conv)
    `CHK("busy", 1'b0, busy)
  endtask

  // One sample through the single step of sequence three, with pulse checks
  task automatic cmp_sample(input logic [DATA_W-1:0] v);
    band_type bnd;
    bnd = (v <= low_band_threshold) ? band_low : (v <= high_band_threshold) ? band_mid : band_high;
    base_data = v ^ {7'h00, step_chan[16]};
    seq_trig[3] = 1'b1;
    tick;
    seq_trig = 4'h0;
    wait_valid;
    `CHK("value", v, out_data.value)
    `CHK("fault_trig", fires(ptrig, cmp_cfg.trig_cond, bnd), fault_trig)
    `CHK("band_irq", fires(pirq, cmp_cfg.irq_cond, bnd), band_irq)
    pop;
  endtask

  initial
  begin
    {rst_n, seq_trig, cmp_trig_reset, cmp_irq_reset, out_ready, slow, avg_log2} = '0;
    {miscompares, n_compared, n_conv, seq_prio} = '0;
    seq_enable = 4'hf;
    seq_last_step = {3'h0, 3'h3, 3'h3, 3'h7};
    cmp_cfg = cmp_cfg_type'(8'h00);
    low_band_threshold = 12'h400;
    high_band_threshold = 12'h800;
    base_data = 12'h123;
    seed = 86307;
    for (int i = 0; i < `STEP_TOTAL; i++) step_chan[i] = 5'(($random(seed) & 32'h7fff) % 17);
    ptrig = '{band_none, 1'b0, 1'b0};
    pirq = ptrig;
    repeat (16) tick;
    rst_n = 1'b1;
    tick;
    // Every averaging setting, including the saturating code 7
    for (int a = 0; a < 8; a++)
    begin
      avg_log2 = a[2:0];
      slow = a[0];
      base_data = 12'($random(seed));
      run_seq(1, 0);
      $display("averaging %0d done", a);
    end
    // Depth limits per sequence, seq zero with the reader stalled
    avg_log2 = 3'h1;
    seq_last_step = {3'h7, 3'h7, 3'h7, 3'h7};
    for (int s = 0; s < 4; s++) run_seq(s, s == 0);
    $display("depth test done");
    // Frequent trigger source sits at low priority so others still run
    seq_prio = {2'h1, 2'h0, 2'h2, 2'h3};
    seq_last_step = '0;
    // Sequence one is triggered while disabled and must never run
    seq_enable = 4'b1101;
    seq_trig = 4'b0111;
    tick;
    seq_trig = 4'h0;
    wait_valid;
    `CHK("first seq", 2'h2, out_data.seq)
    pop;
    wait_valid;
    `CHK("second seq", 2'h0, out_data.seq)
    pop;
    repeat (40) tick;
    `CHK("disabled seq", 1'b0, out_valid)
    seq_enable = 4'hf;
    $display("priority test done");
    // Every trigger condition k paired with interrupt condition 10 - k
    avg_log2 = 3'h0;
    for (int k = 0; k < 11; k++)
    begin
      cmp_cfg.trig_cond = cond_type'(k);
      cmp_cfg.irq_cond = cond_type'(10 - k);
      low_band_threshold = 12'h100 + 12'($random(seed) & 32'h3ff);
      high_band_threshold = low_band_threshold + 12'h001 + 12'($random(seed) & 32'h3ff);
      for (int j = 0; j < 24; j++)
      begin
        slow = $random(seed) & 1;
        {cmp_trig_reset, cmp_irq_reset} = (j == 0) ? 2'b11 : 2'(($random(seed) & 15) >> 2 == 0);
        if (($random(seed) & 7) == 0) cmp_irq_reset = 1'b1;
        if (cmp_trig_reset) ptrig = '{band_none, 1'b0, 1'b0};
        if (cmp_irq_reset) pirq = '{band_none, 1'b0, 1'b0};
        tick;
        {cmp_trig_reset, cmp_irq_reset} = 2'b00;
        case ($random(seed) & 7)
          0: cmp_sample(low_band_threshold);
          1: cmp_sample(low_band_threshold + 12'h001);
          2: cmp_sample(high_band_threshold);
          3: cmp_sample(high_band_threshold + 12'h001);
          4: cmp_sample(12'h000);
          5: cmp_sample(12'hfff);
          default: cmp_sample(12'($random(seed)));
        endcase
      end
      $display("condition %0d done", k);
    end
    close_out;
  end
endmodule
`default_nettype wire
